// ---- pcg_pkg.sv ----
// constants, field layout and carrier types of the pll clock generator control
package pcg_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MAIN       = 8'h00;
  localparam logic [7:0] OFF_BANDWIDTH  = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MAIN_RANGE_LO    = 0;
  localparam int MAIN_RANGE_HI    = 1;
  localparam int MAIN_BCS         = 4;
  localparam int MAIN_PON         = 5;
  localparam int MAIN_FLAG        = 6;
  localparam int BW_ACQ           = 5;
  localparam int BW_LOCK          = 6;
  localparam int BW_AUTO          = 7;
  localparam int IRQ_LOCK_CHANGE  = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_RANGE   = 2'h0;
  localparam logic       RST_PON     = 1'b0;
  localparam logic       RST_BCS     = 1'b0;
  localparam logic       RST_AUTO    = 1'b0;
  localparam logic       RST_ACQ     = 1'b0;
  localparam logic [0:0] RST_IRQ     = 1'h0;

  // ---------------------------------------------------------------
  // timing counts, in clk_i cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] XTAL_HALF     = 4'h8;
  localparam logic [3:0] VCO_HALF_BASE = 4'h8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       auto_bw;
    logic       acq_sel;
    logic       pll_on;
    logic       base_clock_select;
    logic [1:0] range;
  } pcg_ctrl_type;

  // power-of-two range multiplier
  function automatic logic [3:0] vco_mult(input logic [1:0] range);
    logic [3:0] m;
    m = 4'h1;
    unique case (range)
      2'h0: m = 4'h1;
      2'h1: m = 4'h2;
      2'h2: m = 4'h4;
      2'h3: m = 4'h4;
    endcase
    return m;
  endfunction : vco_mult

  // vco half period shrinks with the multiplier
  function automatic logic [3:0] vco_half(input logic [1:0] range);
    logic [3:0] h;
    h = VCO_HALF_BASE / vco_mult(range);
    return h;
  endfunction : vco_half

endpackage : pcg_pkg

// ---- pcg_clk_sel.sv ----
// glitch-free base clock selector
`timescale 1ns/1ps
`default_nettype none

module pcg_clk_sel (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic sel_i,
  input  wire logic force_low_i,
  // sources
  input  wire logic src0_i,
  input  wire logic src1_i,
  // output
  output logic      clk_o,
  output logic      cur_sel_o
);

  logic cur_ff;
  logic out_ff;
  logic cur_src;

  assign cur_src = cur_ff ? src1_i : src0_i;

  // ---------------------------------------------------------------
  // selection swaps only while both sources sit low
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cur_ff <= 1'b0;
    else if (sel_i != cur_ff && !src0_i && !src1_i && !out_ff)
      cur_ff <= sel_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      out_ff <= 1'b0;
    else
      out_ff <= cur_src & ~force_low_i;
  end

  assign clk_o     = out_ff;
  assign cur_sel_o = cur_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sel_no_glitch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(cur_ff) |-> !$past(out_ff))
    else $error("selector switched while output high");

endmodule : pcg_clk_sel

`default_nettype wire

// ---- pcg_top.sv ----
// pll clock generator control: registers, interlocks, stop and clock outputs
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - manual mode: lock bit reads zero, no interrupt from the block
// - bus clock is vco over four with base clock select set, crystal over two otherwise; vco is multiplier times reference
// - clearing pll power-on is ignored while base clock select is set
// - base clock select cannot be set while pll power-on is zero
// - range bits locked while pll on; reset clears them
// - range 00 gives x1, 01 gives x2, 10 gives x4
// - auto bandwidth bit read/write, 1 auto, 0 manual, reset clears
// - bandwidth register shows lock, auto tracking state, manual forced mode
// - stop without keep option: oscillator, pll off; clock and interrupt outputs held low
// - stop with keep option: pll off, oscillator keeps running
// - break with clear enable: cleared status stays cleared afterwards
// - break without clear enable: register accesses leave change flag alone
module pcg_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // system control
  input  wire logic        stop_i,
  input  wire logic        break_i,
  input  wire logic        break_clear_enable_i,
  input  wire logic        osc_keep_in_sleep_i,
  // analog pll status
  input  wire logic        pll_locked_i,
  input  wire logic        pll_tracking_i,
  // analog controls
  output logic             pll_enable_o,
  output logic             osc_enable_o,
  output logic             acquire_mode_o,
  // clocks and interrupt
  output logic             crystal_clock_out_o,
  output logic             vco_clock_o,
  output logic             generated_bus_clock_o,
  output logic             clockgen_interrupt_o
);

  pcg_pkg::pcg_ctrl_type ctrl_ff;
  pcg_pkg::pcg_ctrl_type nxt_ctrl;

  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        lock_s1_ff;
  logic        lock_s2_ff;
  logic        lock_d_ff;
  logic        trk_s1_ff;
  logic        trk_s2_ff;
  logic [0:0]  status_ff;
  logic [0:0]  irq_en_ff;
  logic        irq_ff;
  logic        pll_en_ff;
  logic        osc_en_ff;
  logic        acq_mode_ff;
  logic [3:0]  xcnt_ff;
  logic        xtal_ff;
  logic        xdiv_ff;
  logic [3:0]  vcnt_ff;
  logic        vco_ff;
  logic        vdiv_cnt_ff;
  logic        bus_vco_ff;
  logic        bus_clk;

  logic        setup;
  logic        done;
  logic        wr_main;
  logic        wr_bw;
  logic        wr_clr;
  logic        wr_en;
  logic        rd_main;
  logic        clr_allowed;
  logic        chg_evt;
  logic        lock_vis;
  logic        osc_run;
  logic        pll_run;
  logic        x_tick;
  logic        v_tick;
  logic [3:0]  v_half;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    return a == pcg_pkg::OFF_MAIN || a == pcg_pkg::OFF_BANDWIDTH ||
           a == pcg_pkg::OFF_IRQ_STATUS || a == pcg_pkg::OFF_IRQ_CLEAR ||
           a == pcg_pkg::OFF_IRQ_ENABLE;
  endfunction : is_mapped

  assign setup   = psel_i & ~penable_i;
  assign done    = psel_i & penable_i & pready_ff;
  assign wr_main = done & pwrite_i & (paddr_i == pcg_pkg::OFF_MAIN);
  assign wr_bw   = done & pwrite_i & (paddr_i == pcg_pkg::OFF_BANDWIDTH);
  assign wr_clr  = done & pwrite_i & (paddr_i == pcg_pkg::OFF_IRQ_CLEAR);
  assign wr_en   = done & pwrite_i & (paddr_i == pcg_pkg::OFF_IRQ_ENABLE);
  assign rd_main = done & ~pwrite_i & (paddr_i == pcg_pkg::OFF_MAIN);

  // ---------------------------------------------------------------
  // apb handshake, one access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~is_mapped(paddr_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      prdata_ff <= 32'h0;
    else if (setup && !pwrite_i)
    begin
      prdata_ff <= 32'h0;
      unique case (paddr_i)
        pcg_pkg::OFF_MAIN:
        begin
          prdata_ff[pcg_pkg::MAIN_RANGE_HI:pcg_pkg::MAIN_RANGE_LO] <= ctrl_ff.range;
          prdata_ff[pcg_pkg::MAIN_BCS]  <= ctrl_ff.base_clock_select;
          prdata_ff[pcg_pkg::MAIN_PON]  <= ctrl_ff.pll_on;
          prdata_ff[pcg_pkg::MAIN_FLAG] <= status_ff[pcg_pkg::IRQ_LOCK_CHANGE];
        end
        pcg_pkg::OFF_BANDWIDTH:
        begin
          prdata_ff[pcg_pkg::BW_AUTO] <= ctrl_ff.auto_bw;
          prdata_ff[pcg_pkg::BW_LOCK] <= lock_vis;
          prdata_ff[pcg_pkg::BW_ACQ]  <= ctrl_ff.auto_bw ? trk_s2_ff : ctrl_ff.acq_sel;
        end
        pcg_pkg::OFF_IRQ_STATUS: prdata_ff[0:0] <= status_ff;
        pcg_pkg::OFF_IRQ_ENABLE: prdata_ff[0:0] <= irq_en_ff;
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

  // ---------------------------------------------------------------
  // control register interlocks
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_main)
    begin
      nxt_ctrl.pll_on = pwdata_i[pcg_pkg::MAIN_PON] | ctrl_ff.base_clock_select;
      nxt_ctrl.base_clock_select    = pwdata_i[pcg_pkg::MAIN_BCS] & ctrl_ff.pll_on;
      if (!ctrl_ff.pll_on)
        nxt_ctrl.range = pwdata_i[pcg_pkg::MAIN_RANGE_HI:pcg_pkg::MAIN_RANGE_LO];
    end
    if (wr_bw)
    begin
      nxt_ctrl.auto_bw = pwdata_i[pcg_pkg::BW_AUTO];
      nxt_ctrl.acq_sel = pwdata_i[pcg_pkg::BW_ACQ];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff.auto_bw <= pcg_pkg::RST_AUTO;
      ctrl_ff.acq_sel <= pcg_pkg::RST_ACQ;
      ctrl_ff.pll_on  <= pcg_pkg::RST_PON;
      ctrl_ff.base_clock_select     <= pcg_pkg::RST_BCS;
      ctrl_ff.range   <= pcg_pkg::RST_RANGE;
    end
    else
      ctrl_ff <= nxt_ctrl;
  end

  // ---------------------------------------------------------------
  // pll status synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      lock_d_ff  <= 1'b0;
      trk_s1_ff  <= 1'b0;
      trk_s2_ff  <= 1'b0;
    end
    else
    begin
      lock_s1_ff <= pll_locked_i;
      lock_s2_ff <= lock_s1_ff;
      lock_d_ff  <= lock_s2_ff;
      trk_s1_ff  <= pll_tracking_i;
      trk_s2_ff  <= trk_s1_ff;
    end
  end

  assign lock_vis    = ctrl_ff.auto_bw & lock_s2_ff;
  assign chg_evt     = ctrl_ff.auto_bw & (lock_s2_ff ^ lock_d_ff);
  assign clr_allowed = ~break_i | break_clear_enable_i;

  // ---------------------------------------------------------------
  // interrupt status, enable and output
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      status_ff <= pcg_pkg::RST_IRQ;
    else if (chg_evt)
      status_ff[pcg_pkg::IRQ_LOCK_CHANGE] <= 1'b1;
    else if (clr_allowed && ((wr_clr && pwdata_i[pcg_pkg::IRQ_LOCK_CHANGE]) || rd_main))
      status_ff[pcg_pkg::IRQ_LOCK_CHANGE] <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_en_ff <= pcg_pkg::RST_IRQ;
    else if (wr_en)
      irq_en_ff <= pwdata_i[0:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(status_ff & irq_en_ff) & ctrl_ff.auto_bw & osc_run;
  end

  assign clockgen_interrupt_o = irq_ff;

  // ---------------------------------------------------------------
  // analog controls and stop handling
  // ---------------------------------------------------------------
  assign osc_run = ~(stop_i & ~osc_keep_in_sleep_i);
  assign pll_run = ctrl_ff.pll_on & ~stop_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pll_en_ff   <= 1'b0;
      osc_en_ff   <= 1'b0;
      acq_mode_ff <= 1'b0;
    end
    else
    begin
      pll_en_ff   <= pll_run;
      osc_en_ff   <= osc_run;
      acq_mode_ff <= ctrl_ff.auto_bw ? trk_s2_ff : ctrl_ff.acq_sel;
    end
  end

  assign pll_enable_o   = pll_en_ff;
  assign osc_enable_o   = osc_en_ff;
  assign acquire_mode_o = acq_mode_ff;

  // ---------------------------------------------------------------
  // crystal reference and its half rate
  // ---------------------------------------------------------------
  assign x_tick = (xcnt_ff == pcg_pkg::XTAL_HALF - 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !osc_run)
    begin
      xcnt_ff <= 4'h0;
      xtal_ff <= 1'b0;
      xdiv_ff <= 1'b0;
    end
    else
    begin
      xcnt_ff <= x_tick ? 4'h0 : xcnt_ff + 4'h1;
      if (x_tick)
        xtal_ff <= ~xtal_ff;
      if (x_tick && !xtal_ff)
        xdiv_ff <= ~xdiv_ff;
    end
  end

  assign crystal_clock_out_o = xtal_ff;

  // ---------------------------------------------------------------
  // vco model and divide by four
  // ---------------------------------------------------------------
  assign v_half = pcg_pkg::vco_half(ctrl_ff.range);
  assign v_tick = (vcnt_ff >= v_half - 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !pll_run)
    begin
      vcnt_ff     <= 4'h0;
      vco_ff      <= 1'b0;
      vdiv_cnt_ff <= 1'b0;
      bus_vco_ff  <= 1'b0;
    end
    else
    begin
      vcnt_ff <= v_tick ? 4'h0 : vcnt_ff + 4'h1;
      if (v_tick)
        vco_ff <= ~vco_ff;
      if (v_tick && !vco_ff)
      begin
        vdiv_cnt_ff <= ~vdiv_cnt_ff;
        if (vdiv_cnt_ff)
          bus_vco_ff <= ~bus_vco_ff;
      end
    end
  end

  assign vco_clock_o = vco_ff;

  pcg_clk_sel u_clk_sel (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .sel_i       (ctrl_ff.base_clock_select),
    .force_low_i (stop_i),
    .src0_i      (xdiv_ff),
    .src1_i      (bus_vco_ff),
    .clk_o       (bus_clk),
    .cur_sel_o   ()
  );

  assign generated_bus_clock_o = bus_clk;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pon_clear_block: assert property (
    wr_main && ctrl_ff.base_clock_select |=> ctrl_ff.pll_on)
    else $error("pll power-on cleared while base clock selected");

  a_bcs_needs_pon: assert property (
    wr_main && !ctrl_ff.pll_on |=> !ctrl_ff.base_clock_select)
    else $error("base clock select set with pll off");

  a_range_locked: assert property (
    wr_main && ctrl_ff.pll_on |=> $stable(ctrl_ff.range))
    else $error("range changed while pll on");

  a_manual_no_irq: assert property (
    !ctrl_ff.auto_bw |=> !clockgen_interrupt_o)
    else $error("interrupt in manual mode");

  a_manual_lock_zero: assert property (
    setup && !pwrite_i && paddr_i == pcg_pkg::OFF_BANDWIDTH && !ctrl_ff.auto_bw
    |=> !prdata_o[pcg_pkg::BW_LOCK])
    else $error("lock bit visible in manual mode");

  a_auto_bit_rw: assert property (
    wr_bw |=> ctrl_ff.auto_bw == $past(pwdata_i[pcg_pkg::BW_AUTO]))
    else $error("auto bit not written");

  a_stop_outputs_low: assert property (
    stop_i && !osc_keep_in_sleep_i |=> !crystal_clock_out_o && !clockgen_interrupt_o
    && !generated_bus_clock_o && !osc_enable_o && !pll_enable_o)
    else $error("outputs active in stop");

  a_stop_keep_osc: assert property (
    stop_i && osc_keep_in_sleep_i |=> osc_enable_o && !pll_enable_o)
    else $error("oscillator not kept in stop");

  a_flag_set_wins: assert property (
    chg_evt |=> status_ff[pcg_pkg::IRQ_LOCK_CHANGE] [*1])
    else $error("lock change not flagged");

  a_break_protect: assert property (
    break_i && !break_clear_enable_i && status_ff[pcg_pkg::IRQ_LOCK_CHANGE]
    |=> status_ff[pcg_pkg::IRQ_LOCK_CHANGE])
    else $error("change flag lost during protected break");

  a_break_clear: assert property (
    break_i && break_clear_enable_i && wr_clr && pwdata_i[0] && !chg_evt
    |=> !status_ff[pcg_pkg::IRQ_LOCK_CHANGE])
    else $error("clear ignored during break");

  a_vco_half: assert property (
    pll_run |-> vcnt_ff < v_half &&
    (ctrl_ff.range == 2'h3 || v_half == (pcg_pkg::VCO_HALF_BASE >> ctrl_ff.range)))
    else $error("vco half period decode or counter wrong");

  c_bcs_selected: cover property (wr_main && ctrl_ff.pll_on ##1 ctrl_ff.base_clock_select);
  c_lock_flagged: cover property (chg_evt ##2 clockgen_interrupt_o);
  c_stop_keep:    cover property (stop_i && osc_keep_in_sleep_i ##1 osc_enable_o);

endmodule : pcg_top

`default_nettype wire

// ---- tb.sv ----
// self-checking testbench of the pll clock generator control
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        stop    = 1'b0;
  logic        brk     = 1'b0;
  logic        bce     = 1'b0;
  logic        keep    = 1'b0;
  logic        locked  = 1'b0;
  logic        track   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pll_en;
  logic        osc_en;
  logic        acq_mode;
  logic        xclk;
  logic        vclk;
  logic        bclk;
  logic        irq;
  logic [1:0]  mon_sel = 2'h0;
  logic        mon;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          seed = 32'h6d718b60;
  int          hp;
  int          r;
  int          n;

  always #12.5 clk = ~clk;

  pcg_top i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .stop_i(stop), .break_i(brk),
    .break_clear_enable_i(bce), .osc_keep_in_sleep_i(keep),
    .pll_locked_i(locked), .pll_tracking_i(track), .pll_enable_o(pll_en),
    .osc_enable_o(osc_en), .acquire_mode_o(acq_mode),
    .crystal_clock_out_o(xclk), .vco_clock_o(vclk),
    .generated_bus_clock_o(bclk), .clockgen_interrupt_o(irq));

  always_comb mon = (mon_sel == 2'h0) ? xclk : ((mon_sel == 2'h1) ? vclk : bclk);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // upper bits random, ignored by the block
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    x = $random(seed);
    apb(1'b1, a, {x[31:8], d});
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rd);
  endtask : rchk

  // expected vco half period for range exponent e
  function automatic logic [31:0] vco_exp(input int e);
    return 32'(pcg_pkg::VCO_HALF_BASE) / (32'h1 << e);
  endfunction : vco_exp

  // half period in clk cycles of the monitored clock
  task automatic meas(input logic [1:0] s, output int h);
    logic v;
    mon_sel = s;
    h = 0;
    @(posedge clk);
    v = mon;
    repeat (300)
    begin
      @(posedge clk);
      if (mon !== v) break;
    end
    v = mon;
    repeat (300)
    begin
      @(posedge clk);
      h++;
      if (mon !== v) break;
    end
  endtask : meas

  task automatic toggles(input logic [1:0] s, output int t);
    logic v;
    mon_sel = s;
    t = 0;
    @(posedge clk);
    v = mon;
    repeat (40)
    begin
      @(posedge clk);
      if (mon !== v) t++;
      v = mon;
    end
  endtask : toggles

  task automatic lk;
    @(posedge clk);
    locked <= ~locked;
    repeat (8) @(posedge clk);
  endtask : lk

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rchk("main reset", pcg_pkg::OFF_MAIN, 8'h00);
    rchk("bandwidth reset", pcg_pkg::OFF_BANDWIDTH, 8'h00);
    rchk("status reset", pcg_pkg::OFF_IRQ_STATUS, 8'h00);
    rchk("enable reset", pcg_pkg::OFF_IRQ_ENABLE, 8'h00);
    apb(1'b0, 8'h14 + 8'(($random(seed) & 32'h7) * 4), 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    meas(2'h0, hp);
    chk("crystal half", 32'(pcg_pkg::XTAL_HALF), hp);
    n = $random(seed) & 32'h3;
    for (int k = 0; k < 3; k++)
    begin
      r = (k + n) % 3;
      wr(pcg_pkg::OFF_MAIN, 8'(r));
      rchk("range write", pcg_pkg::OFF_MAIN, 8'(r));
      wr(pcg_pkg::OFF_MAIN, 8'h20 | 8'(r));
      meas(2'h1, hp);
      chk("vco half", vco_exp(r), hp);
      wr(pcg_pkg::OFF_MAIN, 8'h20 | 8'((r + 1) % 3));
      rchk("range locked", pcg_pkg::OFF_MAIN, 8'h20 | 8'(r));
      wr(pcg_pkg::OFF_MAIN, 8'h00);
    end
    wr(pcg_pkg::OFF_MAIN, 8'h10);
    rchk("select refused", pcg_pkg::OFF_MAIN, 8'h00);
    meas(2'h2, hp);
    chk("bus half crystal", 32'(pcg_pkg::XTAL_HALF) * 2, hp);
    wr(pcg_pkg::OFF_MAIN, 8'h20);
    repeat (20) @(posedge clk);
    wr(pcg_pkg::OFF_BANDWIDTH, 8'h20);
    repeat (20) @(posedge clk);
    wr(pcg_pkg::OFF_MAIN, 8'h30);
    rchk("select taken", pcg_pkg::OFF_MAIN, 8'h30);
    repeat (200) @(posedge clk);
    meas(2'h2, hp);
    chk("bus half vco", 32'(pcg_pkg::VCO_HALF_BASE) * 4, hp);
    wr(pcg_pkg::OFF_MAIN, 8'h00);
    rchk("power kept", pcg_pkg::OFF_MAIN, 8'h20);
    wr(pcg_pkg::OFF_MAIN, 8'h00);
    rchk("power off", pcg_pkg::OFF_MAIN, 8'h00);
    wr(pcg_pkg::OFF_BANDWIDTH, 8'h00);
    // manual bandwidth
    wr(pcg_pkg::OFF_IRQ_ENABLE, 8'h01);
    rchk("enable rw", pcg_pkg::OFF_IRQ_ENABLE, 8'h01);
    wr(pcg_pkg::OFF_MAIN, 8'h20);
    repeat (4) @(posedge clk);
    chk("acquire manual", 32'h0, {31'h0, acq_mode});
    wr(pcg_pkg::OFF_BANDWIDTH, 8'h20);
    repeat (4) @(posedge clk);
    chk("track manual", 32'h1, {31'h0, acq_mode});
    lk();
    rchk("lock hidden", pcg_pkg::OFF_BANDWIDTH, 8'h20);
    chk("irq manual", 32'h0, {31'h0, irq});
    wr(pcg_pkg::OFF_IRQ_CLEAR, 8'h01);
    // automatic bandwidth
    wr(pcg_pkg::OFF_BANDWIDTH, 8'h80);
    @(posedge clk);
    track <= 1'b1;
    repeat (6) @(posedge clk);
    chk("track auto", 32'h1, {31'h0, acq_mode});
    rchk("bandwidth auto", pcg_pkg::OFF_BANDWIDTH, 8'he0);
    lk();
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("status set", pcg_pkg::OFF_IRQ_STATUS, 8'h01);
    rchk("flag mirror", pcg_pkg::OFF_MAIN, 8'h60);
    rchk("flag read clear", pcg_pkg::OFF_IRQ_STATUS, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // break handling
    lk();
    @(posedge clk);
    brk <= 1'b1;
    rchk("break read", pcg_pkg::OFF_MAIN, 8'h60);
    wr(pcg_pkg::OFF_IRQ_CLEAR, 8'h01);
    rchk("break protect", pcg_pkg::OFF_IRQ_STATUS, 8'h01);
    @(posedge clk);
    bce <= 1'b1;
    wr(pcg_pkg::OFF_IRQ_CLEAR, 8'h01);
    @(posedge clk);
    brk <= 1'b0;
    bce <= 1'b0;
    rchk("break clear kept", pcg_pkg::OFF_IRQ_STATUS, 8'h00);
    // masking
    wr(pcg_pkg::OFF_IRQ_ENABLE, 8'h00);
    lk();
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("status masked", pcg_pkg::OFF_IRQ_STATUS, 8'h01);
    wr(pcg_pkg::OFF_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    // stop without and with oscillator keep
    @(posedge clk);
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq in stop", 32'h0, {31'h0, irq});
    chk("osc in stop", 32'h0, {31'h0, osc_en});
    chk("pll in stop", 32'h0, {31'h0, pll_en});
    toggles(2'h0, n);
    chk("crystal held", 32'h0, n);
    toggles(2'h2, n);
    chk("bus held", 32'h0, n);
    @(posedge clk);
    keep <= 1'b1;
    repeat (2) @(posedge clk);
    chk("osc kept", 32'h1, {31'h0, osc_en});
    chk("pll shut", 32'h0, {31'h0, pll_en});
    toggles(2'h0, n);
    chk("crystal runs", 32'h1, {31'h0, n >= 4});
    @(posedge clk);
    stop <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pll resumed", 32'h1, {31'h0, pll_en});
    end_sim();
  end
endmodule : tb

`default_nettype wire
